// ==== common/flash_seq_consts.vh ====
// Constants for the flash self-programming sequencer.
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_ADDR_LOW 5'h00
`define OFS_ADDR_HIGH 5'h04
`define OFS_DATA_LOW 5'h08
`define OFS_DATA_HIGH 5'h0C
`define OFS_CONTROL 5'h10
`define OFS_UNLOCK 5'h14
`define OFS_STATUS 5'h18
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define BIT_READ 0
`define BIT_START 1
`define BIT_ALLOW 2
`define BIT_ERR 3
`define BIT_ERASE 4
`define BIT_PSEL 7
// ----------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'hAA
`define BUF_ERASED 14'h3FFF
`define PROT_LIMIT_LOW 16'h0200
`define PROT_LIMIT_HIGH 16'h0400
`define LAST_SLOT 2'b11
`define ROW_LSB 5
`define PROG_TIME_US 2000
`define PWRUP_TIME_US 72000
`define CLK_MHZ 25
`define SETUP_CYCLES 2
`define SKIP_CYCLES 1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ==== hdl/flash_self_erase_write_ctrl.v ====
// Flash self-programming sequencer with an AXI4-Lite register slave.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_consts.vh"

// How it works
// R1: Erase always covers one 32-word row.
// R2: Row from upper 11 address bits.
// R3: No bulk erase beyond one row.
// R4: Software sets select, allow, erase bits.
// R5: Start needs 55h then AAh unlock.
// R6: Two setup cycles squash fetched instructions.
// R7: Erase halts core about 2 ms.
// R8: Halt only stalls core, clocks run.
// R9: Erase resumes at third instruction.
// R10: Writes only into unprotected segments.
// R11: Four-word aligned block, no crossing.
// R12: Software erases before writing.
// R13: Four 14-bit buffers by low bits.
// R14: Software fills all four buffer words.
// R15: Short write loads buffer, clears start.
// R16: Slot 11 loads and programs block.
// R17: Long write: run one, skip one.
// R18: Buffers return to 3FFF after write.
// R19: Reset clears write allow bit.
// R20: Power-up timer blocks writes 72 ms.
// R21: Start needs allow; clearing never aborts.
// R22: Select bit 7, read bit 0.
// R23: Other writes re-arm unlock detector.
// R24: Start clears when operation finishes.
module flash_self_erase_write_ctrl #(
	parameter PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ,
	parameter PWRUP_CYCLES = `PWRUP_TIME_US * `CLK_MHZ,
	parameter ADDR_W = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] write_protect_cfg,
	output wire core_halt_for_write,
	output wire core_squash,
	output reg flash_erase_row,
	output reg flash_program_block,
	output reg [ADDR_W-1:0] flash_addr,
	output reg [55:0] flash_wdata
);

// ----------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------
localparam ST_IDLE = 3'd0;
localparam ST_SETUP = 3'd1;
localparam ST_SKIP = 3'd2;
localparam ST_BUSY = 3'd3;
localparam ST_DONE = 3'd4;

reg [2:0] state_q;
reg [7:0] addr_low_q;
reg [7:0] addr_high_q;
reg [7:0] data_low_q;
reg [5:0] data_high_q;
reg psel_q, erase_q, allow_q, start_q, err_q;
reg [1:0] unlock_q;
reg [13:0] buf_q [0:3];
reg [31:0] cnt_q;
reg [31:0] pwr_cnt_q;
reg pwr_busy_q;
reg aw_hold_q, w_hold_q;
reg [4:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
integer i;

wire [ADDR_W-1:0] full_addr = {addr_high_q, addr_low_q};
wire [1:0] slot = addr_low_q[1:0];

// ----------------------------------------------------------------
// Write protection decode
// ----------------------------------------------------------------
// Protected segment limit grows as the configuration code falls;
// code 11 leaves everything writable.
reg addr_protected;
always @* begin
	case (write_protect_cfg)
	2'b11: addr_protected = 1'b0;
	2'b10: addr_protected = full_addr < `PROT_LIMIT_LOW;
	2'b01: addr_protected = full_addr < `PROT_LIMIT_HIGH;
	default: addr_protected = 1'b1;
	endcase
end

// ----------------------------------------------------------------
// AXI4-Lite slave
// ----------------------------------------------------------------
// Address and data are held separately so they may arrive in
// either order; no new beat is taken until the response is gone.
assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

wire aw_now = s_axi_awvalid && s_axi_awready;
wire w_now = s_axi_wvalid && s_axi_wready;
wire [4:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
wire [3:0] ws = w_hold_q ? wstrb_q : s_axi_wstrb;
wire wr_fire = (aw_hold_q || aw_now) && (w_hold_q || w_now);
wire wr_lane0 = wr_fire && ws[0];
wire wr_mapped = wa <= `OFS_STATUS && wa[1:0] == 2'b00;
wire wr_unlock = wr_lane0 && wa == `OFS_UNLOCK;
wire wr_ctrl = wr_lane0 && wa == `OFS_CONTROL;
wire idle = state_q == ST_IDLE;
wire start_req = wr_ctrl && wd[`BIT_START] && !start_q && idle
	&& unlock_q == 2'd2 && allow_q; // R5 R21
wire go = start_req && !pwr_busy_q; // R20
wire is_erase = psel_q && erase_q; // R4
wire is_long = !erase_q && slot == `LAST_SLOT; // R16

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_hold_q <= 1'b0;
		w_hold_q <= 1'b0;
		awaddr_q <= 5'h00;
		wdata_q <= 32'h0000_0000;
		wstrb_q <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OKAY;
	end else begin
		if (wr_fire) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else begin
			if (aw_now) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_now) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `RESP_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= `RESP_OKAY;
		case (s_axi_araddr)
		`OFS_ADDR_LOW: s_axi_rdata <= {24'h00_0000, addr_low_q};
		`OFS_ADDR_HIGH: s_axi_rdata <= {24'h00_0000, addr_high_q};
		`OFS_DATA_LOW: s_axi_rdata <= {24'h00_0000, data_low_q};
		`OFS_DATA_HIGH: s_axi_rdata <= {26'h000_0000, data_high_q};
		`OFS_CONTROL: s_axi_rdata <= {24'h00_0000, psel_q, 2'b00,
			erase_q, err_q, allow_q, start_q, 1'b0}; // R22
		`OFS_UNLOCK: s_axi_rdata <= 32'h0000_0000;
		`OFS_STATUS: s_axi_rdata <= {29'h0000_0000, pwr_busy_q,
			core_halt_for_write, !idle};
		default: begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_SLVERR;
		end
		endcase
	end else if (s_axi_rready)
		s_axi_rvalid <= 1'b0;
end

// ----------------------------------------------------------------
// Registers, unlock detector, buffers and sequencer
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		addr_low_q <= 8'h00;
		addr_high_q <= 8'h00;
		data_low_q <= 8'h00;
		data_high_q <= 6'h00;
		psel_q <= 1'b0;
		erase_q <= 1'b0;
		allow_q <= 1'b0; // R19
		start_q <= 1'b0;
		err_q <= 1'b0;
		unlock_q <= 2'd0;
		state_q <= ST_IDLE;
		cnt_q <= 32'd0;
		flash_erase_row <= 1'b0;
		flash_program_block <= 1'b0;
		flash_addr <= {ADDR_W{1'b0}};
		flash_wdata <= 56'h00_0000_0000_0000;
		for (i = 0; i < 4; i = i + 1)
			buf_q[i] <= `BUF_ERASED;
	end else begin
		flash_erase_row <= 1'b0;
		flash_program_block <= 1'b0;
		if (wr_lane0 && idle) begin
			if (wa == `OFS_ADDR_LOW) addr_low_q <= wd[7:0];
			if (wa == `OFS_ADDR_HIGH) addr_high_q <= wd[7:0];
			if (wa == `OFS_DATA_LOW) data_low_q <= wd[7:0];
			if (wa == `OFS_DATA_HIGH) data_high_q <= wd[5:0];
		end
		if (wr_ctrl) begin
			// Clearing allow mid-operation does not abort it.
			allow_q <= wd[`BIT_ALLOW]; // R21
			if (idle) begin
				psel_q <= wd[`BIT_PSEL];
				erase_q <= wd[`BIT_ERASE];
				err_q <= wd[`BIT_ERR];
			end
		end
		// Any write other than the expected next one re-arms.
		if (wr_unlock && wd[7:0] == `UNLOCK_KEY1)
			unlock_q <= 2'd1; // R5
		else if (wr_unlock && unlock_q == 2'd1
			&& wd[7:0] == `UNLOCK_KEY2)
			unlock_q <= 2'd2; // R5
		else if (wr_fire)
			unlock_q <= 2'd0; // R23
		if (start_req && pwr_busy_q)
			err_q <= 1'b1; // R20
		case (state_q)
		ST_IDLE: begin
			if (go && is_erase) begin
				start_q <= 1'b1;
				cnt_q <= 32'd0;
				state_q <= ST_SETUP; // R6
			end else if (go && psel_q) begin
				buf_q[slot] <= {data_high_q, data_low_q}; // R13
				start_q <= 1'b1;
				cnt_q <= 32'd0;
				state_q <= is_long ? ST_SKIP : ST_DONE; // R15 R16
			end
		end
		ST_SETUP: begin
			if (cnt_q == `SETUP_CYCLES - 1) begin
				cnt_q <= 32'd0;
				state_q <= ST_BUSY;
				if (addr_protected)
					err_q <= 1'b1; // R10
				else
					flash_erase_row <= 1'b1; // R1 R3
				// Low five bits never reach the array.
				flash_addr <= {full_addr[ADDR_W-1:`ROW_LSB],
					{`ROW_LSB{1'b0}}}; // R2
			end else
				cnt_q <= cnt_q + 32'd1;
		end
		ST_SKIP: begin
			cnt_q <= 32'd0;
			state_q <= ST_BUSY; // R17
			if (addr_protected)
				err_q <= 1'b1; // R10
			else
				flash_program_block <= 1'b1;
			flash_addr <= {full_addr[ADDR_W-1:2], 2'b00}; // R11
			flash_wdata <= {buf_q[3], buf_q[2], buf_q[1], buf_q[0]};
		end
		ST_BUSY: begin
			if (cnt_q == PROG_CYCLES - 1) begin
				state_q <= ST_DONE; // R7
				if (!erase_q)
					for (i = 0; i < 4; i = i + 1)
						buf_q[i] <= `BUF_ERASED; // R18
			end else
				cnt_q <= cnt_q + 32'd1;
		end
		ST_DONE: begin
			start_q <= 1'b0; // R15 R24
			state_q <= ST_IDLE;
		end
		default: state_q <= ST_IDLE;
		endcase
	end
end

// The core is stalled, never put to sleep; clocks keep running.
assign core_halt_for_write = state_q == ST_BUSY; // R7 R8 R9 R16
// Setup cycles of an erase, and the second slot of a long write,
// fetch instructions the core must discard.
assign core_squash = state_q == ST_SETUP || state_q == ST_SKIP; // R6 R17

// ----------------------------------------------------------------
// Power-up write block
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		pwr_cnt_q <= 32'd0;
		pwr_busy_q <= 1'b1;
	end else if (pwr_busy_q) begin
		if (pwr_cnt_q == PWRUP_CYCLES - 1)
			pwr_busy_q <= 1'b0; // R20
		pwr_cnt_q <= pwr_cnt_q + 32'd1;
	end
end

endmodule // flash_self_erase_write_ctrl
`default_nettype wire

// ==== verif/flash_array_model.sv ====
// Flash array stand-in that records array strobes and halt length.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
	input wire aclk,
	input wire flash_erase_row,
	input wire flash_program_block,
	input wire [15:0] flash_addr,
	input wire [55:0] flash_wdata,
	input wire core_halt_for_write,
	output int n_erase,
	output int n_prog,
	output logic [15:0] last_addr,
	output logic [55:0] last_data,
	output int halt_len
);
	int run = 0;
	initial begin
		n_erase = 0;
		n_prog = 0;
		halt_len = 0;
	end
	always @(posedge aclk) begin
		if (flash_erase_row) n_erase <= n_erase + 1;
		if (flash_program_block) n_prog <= n_prog + 1;
		if (flash_erase_row || flash_program_block) begin
			last_addr <= flash_addr;
			last_data <= flash_wdata;
		end
		// The clock keeps running through a halt, so the run is counted.
		run <= core_halt_for_write ? run + 1 : 0;
		if (!core_halt_for_write && run != 0) halt_len <= run;
	end
endmodule // flash_array_model
`default_nettype wire

// ==== verif/flash_self_erase_write_ctrl_test.sv ====
// Self-checking bench for the flash self-programming sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_consts.vh"
module flash_self_erase_write_ctrl_test;
	localparam int PC = 20;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [1:0] s_axi_bresp, s_axi_rresp, write_protect_cfg = 2'b11;
	logic [1:0] wr_resp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, core_halt_for_write, core_squash;
	logic flash_erase_row, flash_program_block;
	logic [15:0] flash_addr, last_addr;
	logic [55:0] flash_wdata, last_data;
	int n_erase, n_prog, halt_len, n_errors = 0, samples_checked = 0, cyc = 0;
	flash_self_erase_write_ctrl #(.PROG_CYCLES(PC), .PWRUP_CYCLES(30)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.write_protect_cfg(write_protect_cfg),
		.core_halt_for_write(core_halt_for_write),
		.core_squash(core_squash), .flash_erase_row(flash_erase_row),
		.flash_program_block(flash_program_block),
		.flash_addr(flash_addr), .flash_wdata(flash_wdata));
	flash_array_model u_model (.aclk(aclk),
		.flash_erase_row(flash_erase_row),
		.flash_program_block(flash_program_block),
		.flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.core_halt_for_write(core_halt_for_write),
		.n_erase(n_erase), .n_prog(n_prog), .last_addr(last_addr),
		.last_data(last_data), .halt_len(halt_len));
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		wr_resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		rd_v = s_axi_rdata;
		s_axi_rready <= 0;
	endtask
	task automatic go(input logic [31:0] c);
		// Allow must already stand before the start write is accepted.
		wr(`OFS_CONTROL, c & 32'hFFFF_FFFD);
		wr(`OFS_UNLOCK, 32'h0000_0055);
		wr(`OFS_UNLOCK, 32'h0000_00AA);
		wr(`OFS_CONTROL, c);
	endtask
	task automatic ld(input logic [7:0] a, input logic [13:0] d);
		wr(`OFS_ADDR_LOW, {24'h0, a});
		wr(`OFS_DATA_LOW, {24'h0, d[7:0]});
		wr(`OFS_DATA_HIGH, {26'h0, d[13:8]});
		go(32'h0000_0086);
	endtask
	task automatic idle;
		do rd(`OFS_CONTROL); while (rd_v[1] !== 1'b0);
	endtask
	task automatic t_pwrup;
		rd(`OFS_STATUS);
		chk("pwrup_block", rd_v[2], 1);
		rd(`OFS_CONTROL);
		chk("allow_rst", rd_v[2], 0);
		ld(8'h03, 14'h0001);
		rd(`OFS_CONTROL);
		chk("err_pwrup", rd_v[3], 1);
		chk("no_prog", n_prog, 0);
		do rd(`OFS_STATUS); while (rd_v[2] !== 1'b0);
		wr(`OFS_CONTROL, 32'h0000_0000);
		$display("t_pwrup done");
	endtask
	task automatic t_erase;
		wr(`OFS_ADDR_HIGH, 32'h0000_0001);
		// This row holds the blocks that the next scenario programs.
		wr(`OFS_ADDR_LOW, 32'h0000_001B);
		go(32'h0000_0096);
		idle;
		chk("erase_cnt", n_erase, 1);
		chk("row_base", last_addr, 16'h0100);
		chk("erase_halt", halt_len, PC);
		chk("erase_noprog", n_prog, 0);
		$display("t_erase done");
	endtask
	task automatic t_block;
		for (int i = 0; i < 3; i++) begin
			ld(8'(4 + i), 14'(14'h2A50 + i));
			rd(`OFS_CONTROL);
			chk("short_done", rd_v[1], 0);
		end
		chk("short_noprog", n_prog, 0);
		ld(8'h07, 14'h2A53);
		rd(`OFS_CONTROL);
		chk("long_busy", rd_v[1], 1);
		idle;
		chk("prog_cnt", n_prog, 1);
		chk("blk_base", last_addr, 16'h0104);
		chk("blk_data", last_data, {14'h2A53, 14'h2A52, 14'h2A51, 14'h2A50});
		chk("prog_halt", halt_len, PC);
		// Only the last slot is loaded, so the rest must read back erased.
		ld(8'h0B, 14'h0123);
		idle;
		chk("refill", last_data, {14'h0123, {3{14'h3FFF}}});
		chk("refill_base", last_addr, 16'h0108);
		$display("t_block done");
	endtask
	task automatic t_refuse;
		wr(`OFS_ADDR_LOW, 32'h0000_0003);
		wr(`OFS_UNLOCK, 32'h0000_0055);
		wr(`OFS_DATA_LOW, 32'h0000_0001);
		wr(`OFS_UNLOCK, 32'h0000_00AA);
		wr(`OFS_CONTROL, 32'h0000_0086);
		rd(`OFS_CONTROL);
		chk("broken_unlock", rd_v[1], 0);
		go(32'h0000_0082);
		rd(`OFS_CONTROL);
		chk("no_allow", rd_v[1], 0);
		write_protect_cfg <= 2'b00;
		go(32'h0000_0086);
		idle;
		rd(`OFS_CONTROL);
		chk("prot_err", rd_v[3], 1);
		chk("refused_cnt", n_prog, 2);
		write_protect_cfg <= 2'b01;
		go(32'h0000_0096);
		idle;
		rd(`OFS_CONTROL);
		chk("prot_erase_err", rd_v[3], 1);
		chk("prot_erase_cnt", n_erase, 1);
		// Row 0x0200 is not below the lower limit, so this erase lands.
		write_protect_cfg <= 2'b10;
		wr(`OFS_ADDR_HIGH, 32'h0000_0002);
		go(32'h0000_0096);
		idle;
		rd(`OFS_CONTROL);
		chk("open_erase_err", rd_v[3], 0);
		chk("open_erase_cnt", n_erase, 2);
		chk("open_erase_base", last_addr, 16'h0200);
		write_protect_cfg <= 2'b11;
		$display("t_refuse done");
	endtask
	task automatic t_bus;
		wr(`OFS_CONTROL, 32'h0000_0081);
		chk("wr_okay", wr_resp, `RESP_OKAY);
		rd(`OFS_CONTROL);
		chk("sel_bit", rd_v[7], 1);
		chk("read_bit", rd_v[0], 0);
		rd(5'h1C);
		chk("unmapped_resp", s_axi_rresp, `RESP_SLVERR);
		chk("unmapped_data", rd_v, 0);
		wr(5'h1C, 32'h0000_0000);
		chk("wr_unmapped", wr_resp, `RESP_SLVERR);
		$display("t_bus done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		t_pwrup;
		t_erase;
		t_block;
		t_refuse;
		t_bus;
		tally_and_finish;
	end
endmodule // flash_self_erase_write_ctrl_test
`default_nettype wire

// ==== verif/flash_seq_sva.sv ====
// Port assertions for the flash self-programming sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_seq_sva #(
	parameter PROG_CYCLES = 20,
	parameter ADDR_W = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire [1:0] write_protect_cfg,
	input wire core_halt_for_write,
	input wire core_squash,
	input wire flash_erase_row,
	input wire flash_program_block,
	input wire [ADDR_W-1:0] flash_addr
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	int hcnt;
	always @(posedge aclk)
		if (!aresetn || !core_halt_for_write) hcnt <= 0;
		else hcnt <= hcnt + 1;
	a_row_base: assert property (
		flash_erase_row |-> flash_addr[4:0] == 5'h00) else $error("row");
	a_block_base: assert property (
		flash_program_block |-> flash_addr[1:0] == 2'b00) else $error("blk");
	a_halt_len: assert property (
		$fell(core_halt_for_write) |-> hcnt == PROG_CYCLES) else $error("len");
	a_squash_long: assert property (
		flash_program_block |-> $past(core_squash)) else $error("skip");
	a_squash_erase: assert property (
		flash_erase_row |-> $past(core_squash) && $past(core_squash, 2))
		else $error("setup");
	a_protect_all: assert property (
		write_protect_cfg == 2'b00 |-> !flash_program_block && !flash_erase_row)
		else $error("prot");
	a_pulse_halt: assert property (
		flash_program_block || flash_erase_row |-> core_halt_for_write)
		else $error("halt");
	a_read_in_halt: assert property (
		core_halt_for_write && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("bus");
	c_erase: cover property (flash_erase_row);
	c_prog: cover property (flash_program_block);
	c_halt_end: cover property ($fell(core_halt_for_write));
endmodule // flash_seq_sva
bind flash_self_erase_write_ctrl flash_seq_sva #(
	.PROG_CYCLES(PROG_CYCLES), .ADDR_W(ADDR_W)) u_sva (
	.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.write_protect_cfg(write_protect_cfg),
	.core_halt_for_write(core_halt_for_write), .core_squash(core_squash),
	.flash_erase_row(flash_erase_row),
	.flash_program_block(flash_program_block), .flash_addr(flash_addr));
`default_nettype wire
